// ==== shared/bths_pkg.sv ====
package bths_pkg;

  // One byte on a byte stream, with its strobe.
  typedef struct packed {
    logic       vld;
    logic [7:0] dat;
  } bths_byte_t;

  // End of one bus attempt: acknowledge kind and frame condition flags.
  typedef struct packed {
    logic       vld;
    logic [1:0] res;
    logic [2:0] flg;
  } bths_done_t;

  localparam logic [1:0] RES_ACK     = 2'h0;
  localparam logic [1:0] RES_BUSY    = 2'h2;
  localparam logic [1:0] MODE_NORMAL = 2'h3;

  // Request codes: upper bits select the service, lower bits carry a field.
  localparam logic [4:0] OP_OFFS  = 5'h01;
  localparam logic [4:0] OP_CFG   = 5'h03;
  localparam logic [4:0] OP_REGWR = 5'h05;
  localparam logic [4:0] OP_REGRD = 5'h07;
  localparam logic [3:0] OP_POLL  = 4'hE;
  localparam logic [1:0] OP_END   = 2'h1;
  localparam logic [1:0] OP_CONT  = 2'h2;

  // Indication codes sent back to the host.
  localparam logic [2:0] CFG_IND_CODE = 3'h1;
  localparam logic [2:0] FST_CODE     = 3'h3;
  localparam logic [7:0] MARK_CODE    = 8'hCB;
  localparam logic [7:0] CONF_CODE    = 8'h0B;
  localparam logic [7:0] STATE_RE     = 8'h87;

  localparam logic [2:0]  FEAT_RST   = 3'h0;
  localparam logic [2:0]  RETRY_INIT = 3'h3;
  localparam logic [15:0] CRC_INIT   = 16'hFFFF;
  localparam int          FRAME_MAX  = 263;

  // Timing: bit times at the bus rate and the host frame-end silence.
  localparam longint CLK_HZ      = 20_000_000;
  localparam longint BAUD        = 9600;
  localparam longint BUSY_BITS   = 150;
  localparam longint NACK_BITS   = 50;
  localparam longint SILENCE_US  = 2600;
  localparam longint BUSY_CYC    = (BUSY_BITS * CLK_HZ + BAUD - 1) / BAUD;
  localparam longint NACK_CYC    = (NACK_BITS * CLK_HZ + BAUD - 1) / BAUD;
  localparam longint SILENCE_CYC = (SILENCE_US * CLK_HZ + 999_999) / 1_000_000;

endpackage

// ==== hw/bths_core.sv ====
`timescale 1ns/1ps
// Functional notes
// R1: Optional features off after every reset.
// R2: Apply features when idle; indicate then.
// R3: Keep host poll data for poll slots.
// R4: CRC feature appends two CRC bytes.
// R5: Frame end: silence, or marker plus state.
// R6: Config indication reports five feature bits.
// R7: One activates, zero keeps, zeros just query.
// R8: Register write takes following data byte.
// R9: Register read returns addressed byte next.
// R10: Host writes registers only when quiet.
// R11: Host reads registers only when stopped.
// R12: Frame start: control byte, offset cleared.
// R13: Continue request stores byte at index.
// R14: Offset request gives upper index bits.
// R15: Host never sends offsets five to seven.
// R16: Checksum match sends, mismatch reports error.
// R17: Bus sending starts after full assembly.
// R18: Every transmitted octet echoed to host.
// R19: Frame state then confirmation with ack MSB.
// R20: Frame state: three flags, reserved zeros.
// R21: Without repeat, exactly one send attempt.
// R22: Marker on: octet 0xCB echoed twice.
// R23: Retry counters three; busy 150, other 50.
// R24: CRC 1021, init FFFF, unreflected.
module bths_core #(
  parameter int unsigned BUSY_GAP = 32'(bths_pkg::BUSY_CYC),
  parameter int unsigned NACK_GAP = 32'(bths_pkg::NACK_CYC),
  parameter int unsigned SIL_CYC  = 32'(bths_pkg::SILENCE_CYC)
) (
  // Clock and reset.
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_b,
  // Host link byte streams.
  input  wire bths_pkg::bths_byte_t i_host,
  output bths_pkg::bths_byte_t      o_host,
  // Device state inputs.
  input  wire logic                 i_bus_idle,
  input  wire logic [1:0]           i_mode,
  input  wire logic                 i_busy_mode,
  input  wire logic                 i_autoack,
  input  wire logic                 i_repeat_en,
  // Active features.
  output logic [2:0]                o_feat,
  // Stored polling information.
  output logic                      o_poll_vld,
  output logic [3:0]                o_poll_slot,
  output logic [7:0]                o_poll_adr,
  output logic [7:0]                o_poll_dat,
  // Internal register port.
  output logic [2:0]                o_reg_addr,
  output logic                      o_reg_wr,
  output logic                      o_reg_rd,
  output logic [7:0]                o_reg_wdat,
  input  wire logic [7:0]           i_reg_rdat,
  // Bus transmitter.
  output bths_pkg::bths_byte_t      o_bus,
  input  wire logic                 i_bus_rdy,
  input  wire bths_pkg::bths_done_t i_bus_done,
  // Bus receiver stream.
  input  wire bths_pkg::bths_byte_t i_rx,
  input  wire logic                 i_rx_end,
  input  wire logic [2:0]           i_rx_flg
);

  typedef enum logic [3:0] {P_CMD, P_DATA, P_CKS, P_REGW, P_PADR, P_PST,
                            P_SUM, P_TX, P_WAIT, P_GAP} bths_pst_t;
  typedef enum logic [3:0] {O_IDLE, O_DUP, O_CRCH, O_CRCL, O_MARK, O_FST,
                            O_CONF, O_SIL} bths_ost_t;

  // Serial CRC update, one byte at a time, no reflection.
  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] x;
    x = {c[7:0], c[15:8]} ^ {8'h00, b};
    x = x ^ {12'h000, x[7:4]};
    x = x ^ {x[3:0], 12'h000};
    x = x ^ {3'b000, x[7:0], 5'b00000};
    return x;
  endfunction

  bths_pst_t   st_q;           // Request parser and sender state.
  bths_ost_t   ost_q;          // Host output sequencer state.
  logic [7:0]  buf_q [bths_pkg::FRAME_MAX];  // Assembled telegram.
  logic [2:0]  req_q;          // Features waiting to be applied.
  logic        cfg_pend_q;     // A configuration request is waiting.
  logic        cfg_ind_q;      // Configuration indication owed.
  logic        rd_pend_q;      // Register read data owed.
  logic [7:0]  rd_dat_q;       // Captured register data.
  logic        st_pend_q;      // Checksum error indication owed.
  logic        end_pend_q;     // Frame tail owed.
  logic        conf_pend_q;    // Data confirmation owed.
  logic [7:0]  conf_q;         // Confirmation byte.
  logic [2:0]  fst_flg_q;      // Flags of the frame that ended.
  logic [2:0]  off_q;          // Upper index bits.
  logic [8:0]  wa_q;           // Write index for the next data byte.
  logic [8:0]  len_q;          // Telegram length before checksum.
  logic [8:0]  ptr_q;          // Scan and send pointer.
  logic [7:0]  sum_q;          // Running XOR of the telegram.
  logic [7:0]  cks_q;          // Checksum from the host.
  logic [2:0]  bcnt_q;         // Busy retries left.
  logic [2:0]  ncnt_q;         // Other retries left.
  logic [19:0] gap_q;          // Idle cycles counted before a retry.
  logic [19:0] gap_tgt_q;      // Idle cycles needed before a retry.
  logic [19:0] sil_q;          // Silence cycles still to keep.
  logic [15:0] crc_q;          // CRC over the bytes forwarded.

  ////////////////////////////////////////////////////////////////////////////////
  // Decoding of host bytes and events.

  wire       hv        = i_host.vld;
  wire [7:0] hb        = i_host.dat;
  wire       cmd       = hv && (st_q == P_CMD);
  wire       is_cont   = hb[7:6] == bths_pkg::OP_CONT;
  wire       is_end    = hb[7:6] == bths_pkg::OP_END;
  wire       is_start  = is_cont && (hb[5:0] == 6'h00);
  wire       cfg_apply = cfg_pend_q && (i_bus_idle || i_mode != bths_pkg::MODE_NORMAL);
  wire       bus_fire  = o_bus.vld && i_bus_rdy;
  wire       strm      = bus_fire || i_rx.vld;
  wire [7:0] strm_dat  = bus_fire ? o_bus.dat : i_rx.dat;
  wire       out_free  = (ost_q == O_IDLE) || (ost_q == O_SIL);
  wire       mark_on   = o_feat[0];
  wire       done      = i_bus_done.vld && (st_q == P_WAIT);
  wire       is_busy   = i_bus_done.res == bths_pkg::RES_BUSY;
  wire       is_ack    = i_bus_done.res == bths_pkg::RES_ACK;
  wire       left      = is_busy ? (bcnt_q != 3'h0) : (ncnt_q != 3'h0);
  wire       retry     = done && !is_ack && i_repeat_en && left;
  wire       final_ev  = done && !retry;
  wire       sum_end   = (st_q == P_SUM) && (ptr_q == len_q);
  wire       sum_ok    = ~sum_q == cks_q;
  wire [8:0] cont_idx  = {off_q, hb[5:0]};
  wire       buf_we    = hv && (((st_q == P_DATA) && (wa_q < 9'(bths_pkg::FRAME_MAX))) ||
                                ((st_q == P_CKS) && (len_q < 9'(bths_pkg::FRAME_MAX))));
  wire [8:0] buf_wa    = (st_q == P_CKS) ? len_q : wa_q;
  wire [7:0] cfg_ind   = {i_busy_mode, i_autoack, o_feat, bths_pkg::CFG_IND_CODE};
  wire [7:0] fst_byte  = {fst_flg_q, 2'b00, bths_pkg::FST_CODE};  // [R20]
  wire [7:0] rd_byte   = buf_q[ptr_q];

  ////////////////////////////////////////////////////////////////////////////////
  // Telegram buffer: no reset; an index left unwritten is sent with whatever it last held.

  // Bytes land at any index in any order; a rewrite replaces the old byte.
  always_ff @(posedge i_clk) begin
    if (buf_we) begin
      buf_q[buf_wa] <= hb;  // [R13]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Feature configuration.

  // Requested bits only ever add features; reset alone clears them.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_feat     <= bths_pkg::FEAT_RST;  // [R1]
      req_q      <= 3'h0;
      cfg_pend_q <= 1'b0;
    end else if (cmd && hb[7:3] == bths_pkg::OP_CFG) begin
      req_q      <= req_q | hb[2:0];  // [R7]
      cfg_pend_q <= 1'b1;
    end else if (cfg_apply) begin
      o_feat     <= o_feat | req_q;  // [R2] [R7]
      req_q      <= 3'h0;
      cfg_pend_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Request parser and telegram sender.

  // One state machine walks requests, checksum scan, sending and retries.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_q <= P_CMD;
      off_q <= 3'h0;
      wa_q <= 9'h000;
      len_q <= 9'h000;
      ptr_q <= 9'h000;
      sum_q <= 8'h00;
      cks_q <= 8'h00;
      bcnt_q <= bths_pkg::RETRY_INIT;
      ncnt_q <= bths_pkg::RETRY_INIT;
      gap_q <= 20'h00000;
      gap_tgt_q <= 20'h00000;
      o_bus <= '0;
    end else begin
      case (st_q)
        P_CMD: begin
          if (hv && is_start) begin
            off_q <= 3'h0;  // [R12]
            wa_q  <= 9'h000;
            st_q  <= P_DATA;
          end else if (hv && is_cont) begin
            wa_q <= cont_idx;  // [R13] [R14]
            st_q <= P_DATA;
          end else if (hv && is_end) begin
            len_q <= cont_idx;
            st_q  <= P_CKS;
          end else if (hv && hb[7:3] == bths_pkg::OP_OFFS) begin
            off_q <= hb[2:0];  // [R14] [R15]
          end else if (hv && hb[7:3] == bths_pkg::OP_REGWR) begin
            st_q <= P_REGW;  // [R8] [R10]
          end else if (hv && hb[7:4] == bths_pkg::OP_POLL) begin
            st_q <= P_PADR;  // [R3]
          end
        end
        P_DATA, P_REGW, P_PST: begin
          if (hv) begin
            st_q <= P_CMD;
          end
        end
        P_PADR: begin
          if (hv) begin
            st_q <= P_PST;
          end
        end
        P_CKS: begin
          // Checksum byte ends assembly; the scan runs before any sending.
          if (hv) begin
            cks_q <= hb;
            sum_q <= 8'h00;
            ptr_q <= 9'h000;
            st_q  <= P_SUM;
          end
        end
        P_SUM: begin
          if (sum_end) begin
            ptr_q  <= 9'h000;
            bcnt_q <= bths_pkg::RETRY_INIT;  // [R23]
            ncnt_q <= bths_pkg::RETRY_INIT;
            st_q   <= sum_ok ? P_TX : P_CMD;  // [R16] [R17]
          end else begin
            sum_q <= sum_q ^ rd_byte;
            ptr_q <= ptr_q + 9'h001;
          end
        end
        P_TX: begin
          // A byte is offered only when the echo path is free.
          if (bus_fire) begin
            o_bus.vld <= 1'b0;
            ptr_q     <= ptr_q + 9'h001;
            st_q      <= (ptr_q == len_q) ? P_WAIT : P_TX;
          end else if (!o_bus.vld && ost_q == O_IDLE && !i_rx.vld) begin
            o_bus.vld <= 1'b1;  // [R17]
            o_bus.dat <= (ptr_q == len_q) ? cks_q : rd_byte;
          end
        end
        P_WAIT: begin
          if (retry) begin
            // Busy waits the long gap, any other failure the short one.
            bcnt_q    <= is_busy ? bcnt_q - 3'h1 : bcnt_q;  // [R23]
            ncnt_q    <= is_busy ? ncnt_q : ncnt_q - 3'h1;
            gap_tgt_q <= is_busy ? BUSY_GAP[19:0] : NACK_GAP[19:0];
            gap_q     <= 20'h00000;
            st_q      <= P_GAP;
          end else if (done) begin
            st_q <= P_CMD;  // [R21]
          end
        end
        P_GAP: begin
          // The gap counts only unbroken bus idle.
          gap_q <= i_bus_idle ? gap_q + 20'h00001 : 20'h00000;
          if (i_bus_idle && gap_q + 20'h00001 >= gap_tgt_q) begin
            ptr_q <= 9'h000;
            st_q  <= P_TX;
          end
        end
        default: st_q <= P_CMD;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register port and polling store.

  // Read data is captured one cycle after the read strobe.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_reg_addr  <= 3'h0;
      o_reg_wr    <= 1'b0;
      o_reg_rd    <= 1'b0;
      o_reg_wdat  <= 8'h00;
      rd_dat_q    <= 8'h00;
      o_poll_vld  <= 1'b0;
      o_poll_slot <= 4'h0;
      o_poll_adr  <= 8'h00;
      o_poll_dat  <= 8'h00;
    end else begin
      o_reg_wr <= hv && (st_q == P_REGW);  // [R8]
      o_reg_rd <= cmd && hb[7:3] == bths_pkg::OP_REGRD;  // [R9] [R11]
      if (cmd && (hb[7:3] == bths_pkg::OP_REGRD || hb[7:3] == bths_pkg::OP_REGWR)) begin
        o_reg_addr <= hb[2:0];
      end
      if (hv && st_q == P_REGW) begin
        o_reg_wdat <= hb;
      end
      if (o_reg_rd) begin
        rd_dat_q <= i_reg_rdat;  // [R9]
      end
      if (cmd && hb[7:4] == bths_pkg::OP_POLL) begin
        o_poll_slot <= hb[3:0];  // [R3]
      end
      if (hv && st_q == P_PADR) begin
        o_poll_adr <= hb;
      end
      if (hv && st_q == P_PST) begin
        o_poll_dat <= hb;
        o_poll_vld <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Owed indications: a new event always wins over its own clear.

  wire emit_cfg = (ost_q == O_IDLE) && !strm && !end_pend_q && cfg_ind_q;
  wire emit_rd  = (ost_q == O_IDLE) && !strm && !end_pend_q && !cfg_ind_q && rd_pend_q;
  wire emit_st  = (ost_q == O_IDLE) && !strm && !end_pend_q && !cfg_ind_q && !rd_pend_q
                  && st_pend_q;
  wire take_end = out_free && !strm && end_pend_q;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cfg_ind_q   <= 1'b0;
      rd_pend_q   <= 1'b0;
      st_pend_q   <= 1'b0;
      end_pend_q  <= 1'b0;
      conf_pend_q <= 1'b0;
      conf_q      <= 8'h00;
      fst_flg_q   <= 3'h0;
    end else begin
      cfg_ind_q  <= cfg_apply | (cfg_ind_q & ~emit_cfg);  // [R2]
      rd_pend_q  <= o_reg_rd | (rd_pend_q & ~emit_rd);
      st_pend_q  <= (sum_end & ~sum_ok) | (st_pend_q & ~emit_st);  // [R16]
      end_pend_q <= final_ev | i_rx_end | (end_pend_q & ~take_end);
      if (final_ev) begin
        conf_pend_q <= 1'b1;
        conf_q      <= {is_ack, bths_pkg::CONF_CODE[6:0]};  // [R19]
        fst_flg_q   <= i_bus_done.flg;
      end else if (ost_q == O_CONF) begin
        conf_pend_q <= 1'b0;
      end
      if (i_rx_end) begin
        fst_flg_q <= i_rx_flg;  // [R20]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Host output sequencer.

  // Tail order: CRC, marker, frame state, confirmation; silence follows only with the marker off.
  wire bths_ost_t after_fst = conf_pend_q ? O_CONF : (mark_on ? O_IDLE : O_SIL);
  wire bths_ost_t tail_1st  = o_feat[1] ? O_CRCH : (mark_on ? O_MARK : O_FST);

  // Data bytes preempt silence; a limitation if the bus restarts early.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ost_q <= O_IDLE;
      o_host <= '0;
      crc_q <= bths_pkg::CRC_INIT;
      sil_q <= 20'h00000;
    end else begin
      o_host.vld <= 1'b0;
      case (ost_q)
        O_IDLE, O_SIL: begin
          sil_q <= (sil_q != 20'h00000) ? sil_q - 20'h00001 : sil_q;
          if (ost_q == O_SIL && sil_q == 20'h00001) begin
            ost_q <= O_IDLE;  // [R5]
          end
          if (strm) begin
            o_host <= '{vld: 1'b1, dat: strm_dat};  // [R18]
            crc_q  <= crc_upd(crc_q, strm_dat);  // [R24]
            ost_q  <= (mark_on && strm_dat == bths_pkg::MARK_CODE) ? O_DUP : O_IDLE;
          end else if (take_end) begin
            ost_q <= tail_1st;  // [R4] [R5]
          end else if (emit_cfg) begin
            o_host <= '{vld: 1'b1, dat: cfg_ind};  // [R6]
          end else if (emit_rd) begin
            o_host <= '{vld: 1'b1, dat: rd_dat_q};
          end else if (emit_st) begin
            o_host <= '{vld: 1'b1, dat: bths_pkg::STATE_RE};
          end
        end
        O_DUP: begin
          o_host <= '{vld: 1'b1, dat: bths_pkg::MARK_CODE};  // [R22]
          ost_q  <= O_IDLE;
        end
        O_CRCH: begin
          o_host <= '{vld: 1'b1, dat: crc_q[15:8]};  // [R4]
          ost_q  <= O_CRCL;
        end
        O_CRCL: begin
          o_host <= '{vld: 1'b1, dat: crc_q[7:0]};
          ost_q  <= mark_on ? O_MARK : O_FST;
        end
        O_MARK: begin
          o_host <= '{vld: 1'b1, dat: bths_pkg::MARK_CODE};  // [R5]
          ost_q  <= O_FST;
        end
        O_FST: begin
          o_host <= '{vld: 1'b1, dat: fst_byte};  // [R19] [R20]
          crc_q  <= bths_pkg::CRC_INIT;
          sil_q  <= SIL_CYC[19:0];
          ost_q  <= after_fst;
        end
        O_CONF: begin
          o_host <= '{vld: 1'b1, dat: conf_q};  // [R19]
          ost_q  <= mark_on ? O_IDLE : O_SIL;
        end
        default: ost_q <= O_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence echo_once_s;
    o_host.vld && o_host.dat == bths_pkg::MARK_CODE;
  endsequence

  feat_keep_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R7]
    ($past(o_feat) & ~o_feat) == 3'h0)
    else $error("feature deactivated without reset");
  feat_when_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R2]
    $changed(o_feat) |-> ($past(i_bus_idle) || $past(i_mode) != bths_pkg::MODE_NORMAL) ##1
      o_host.vld && o_host.dat[2:0] == bths_pkg::CFG_IND_CODE)
    else $error("features changed outside idle or without indication");
  start_off_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R12]
    cmd && is_start |=> off_q == 3'h0 && st_q == P_DATA)
    else $error("frame start did not clear offset");
  tx_gate_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R17]
    $rose(o_bus.vld) |-> $past(st_q) == P_TX)
    else $error("bus byte offered before assembly");
  echo_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R18]
    bus_fire |=> o_host.vld && o_host.dat == $past(o_bus.dat))
    else $error("transmitted octet not echoed");
  dup_mark_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R22]
    bus_fire && mark_on && o_bus.dat == bths_pkg::MARK_CODE |=> echo_once_s ##1 echo_once_s)
    else $error("marker code octet not doubled");
  cks_bad_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R16]
    sum_end && !sum_ok |=> st_pend_q && st_q == P_CMD)
    else $error("checksum mismatch not reported");
  one_try_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R21]
    done && !i_repeat_en |=> st_q == P_CMD)
    else $error("retry without repeat setting");
  retry_init_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R23]
    $past(st_q) == P_SUM && st_q == P_TX |-> bcnt_q == 3'h3 && ncnt_q == 3'h3)
    else $error("retry counters not loaded with three");
  conf_after_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R19]
    ost_q == O_FST && conf_pend_q |=> ost_q == O_CONF ##1 o_host.vld && o_host.dat[6:0] == 7'h0B)
    else $error("confirmation not after frame state");

endmodule

// ==== testbench/bths_bus_model.sv ====
`timescale 1ns/1ps
// Bus transmitter stand-in: stalls half the time and ends each attempt.
module bths_bus_model (
  // Clock and reset.
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_b,
  // Byte offered by the block and the outcome to report.
  input  wire bths_pkg::bths_byte_t i_bus,
  input  wire logic [8:0]           i_len,
  input  wire logic [4:0]           i_end,
  // Answers to the block.
  output logic                      o_rdy,
  output bths_pkg::bths_done_t      o_done,
  output logic [8:0]                o_cnt
);
  logic [1:0] div_q; // Two ready cycles out of four, so offers must wait.
  assign o_rdy = div_q[1];
  // Count accepted bytes; the byte that reaches the target ends the attempt.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      div_q  <= 2'h0;
      o_cnt  <= 9'h000;
      o_done <= '0;
    end else begin
      div_q  <= div_q + 2'h1;
      o_done <= '0;
      if (i_bus.vld && o_rdy) begin
        o_cnt <= o_cnt + 9'h001;
        if (o_cnt + 9'h001 == i_len) o_done <= {1'b1, i_end};
      end
    end
  end
endmodule

// ==== testbench/bths_core_test.sv ====
`timescale 1ns/1ps
// Self-checking bench for the host service interpreter.
module bths_core_test;
  logic                 i_clk = 1'b0;
  logic                 i_rst_b = 1'b0;
  bths_pkg::bths_byte_t i_host = '0, o_host, o_bus, rx = '0;
  bths_pkg::bths_done_t done;
  logic                 i_bus_idle = 1'b1, i_busy_mode = 1'b0, i_autoack = 1'b0;
  logic                 bus_rdy, reg_wr, reg_rd, poll_vld, repeat_en = 1'b0, rx_end = 1'b0;
  logic [1:0]           i_mode = 2'h2;
  logic [2:0]           o_feat, reg_addr, wr_a, rd_a, rx_flg = 3'h0;
  logic [3:0]           poll_slot;
  logic [7:0]           poll_adr, poll_dat, reg_wdat, wr_d, i_reg_rdat = 8'h00;
  logic [8:0]           len = 9'h000, cnt;
  logic [15:0]          crc_exp = 16'hFFFF;
  logic [4:0]           ending = 5'h00;
  logic [7:0]           got[$], expq[$];
  int                   errors = 0, samples_checked = 0, seed = 66710, cycles = 0;

  always #25 i_clk = ~i_clk;

  // Short gaps keep retries and the silence after a frame brief.
  bths_core #(.BUSY_GAP(20), .NACK_GAP(10), .SIL_CYC(8)) dut (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_host(i_host), .o_host(o_host),
    .i_bus_idle(i_bus_idle), .i_mode(i_mode), .i_busy_mode(i_busy_mode),
    .i_autoack(i_autoack), .i_repeat_en(repeat_en), .o_feat(o_feat), .o_poll_vld(poll_vld),
    .o_poll_slot(poll_slot), .o_poll_adr(poll_adr), .o_poll_dat(poll_dat),
    .o_reg_addr(reg_addr), .o_reg_wr(reg_wr), .o_reg_rd(reg_rd), .o_reg_wdat(reg_wdat),
    .i_reg_rdat(i_reg_rdat), .o_bus(o_bus), .i_bus_rdy(bus_rdy), .i_bus_done(done),
    .i_rx(rx), .i_rx_end(rx_end), .i_rx_flg(rx_flg));
  bths_bus_model far (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_bus(o_bus), .i_len(len),
    .i_end(ending), .o_rdy(bus_rdy), .o_done(done), .o_cnt(cnt));

  ////////////////////////////////////////////////////////////////////////////////
  // Collect host bytes and register writes; cut a hang short.
  always @(posedge i_clk) begin
    cycles++;
    if (o_host.vld === 1'b1) got.push_back(o_host.dat);
    if (reg_wr === 1'b1) begin
      wr_a = reg_addr;
      wr_d = reg_wdat;
    end
    if (reg_rd === 1'b1) rd_a = reg_addr;
    if (cycles == 20000) begin
      errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // One request byte, strobed for one cycle just after an edge.
  task automatic send(input logic [7:0] b);
    @(posedge i_clk);
    #1 i_host = {1'b1, b};
    @(posedge i_clk);
    #1 i_host = '0;
  endtask

  // Wait for the expected host stream, then compare it byte by byte.
  task automatic expect_bytes();
    for (int k = 0; k < 400 && got.size() < expq.size(); k++) @(posedge i_clk);
    repeat (12) @(posedge i_clk);
    #1;
    chk(8'(got.size()), 8'(expq.size()));
    foreach (expq[k]) chk(got[k], expq[k]);
    got.delete();
    expq.delete();
  endtask

  // The marker is on for all sent frames, so a marker-valued octet comes twice.
  function automatic void echo(input logic [7:0] b);
    expq.push_back(b);
    if (b == 8'hCB) expq.push_back(b);
  endfunction

  // Bitwise CRC, polynomial 1021, no reflection, one byte per call.
  function automatic logic [15:0] crc_next(input logic [15:0] c, input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? 16'h1021 : 16'h0000);
    end
    return c;
  endfunction

  // Assemble a six-byte telegram out of order, then finish it.
  task automatic frame(input logic bad, input logic [1:0] res);
    logic [7:0] d[6];
    logic [7:0] x;
    #1 x = 8'hFF;
    foreach (d[i]) d[i] = 8'($random(seed));
    d[2] = 8'hCB;
    foreach (d[i]) x = x ^ d[i];
    ending = {res, 3'($random(seed))};
    len = cnt + 9'd7;
    send(8'h09);
    send(8'h80);
    send(d[0]);
    for (int i = 5; i > 0; i--) begin
      send(8'h80 | 8'(i));
      send(i == 1 ? ~d[1] : d[i]);
    end
    send(8'h81);
    send(d[1]);
    chk(8'(len - cnt), 8'h07);
    send(8'h46);
    send(x ^ {7'h00, bad});
    if (bad) expq.push_back(8'h87);
    else begin
      // A refused attempt with repeat on is sent three more times.
      if (repeat_en && res != 2'h0) repeat (3) begin
        wait (cnt == len);
        #1 len = len + 9'd7;
      end
      repeat (repeat_en && res != 2'h0 ? 4 : 1) begin
        foreach (d[i]) echo(d[i]);
        echo(x);
      end
      expq.push_back(8'hCB);
      expq.push_back({ending[2:0], 5'h03});
      expq.push_back({res == 2'h0, 7'h0B});
    end
    expect_bytes();
    chk(8'(len - cnt), bad ? 8'h07 : 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge i_clk);
    #1 i_rst_b = 1'b1;
    chk({5'h00, o_feat}, 8'h00);
    i_busy_mode = 1'($random(seed));
    i_autoack = 1'($random(seed));
    send(8'h19);
    expq.push_back({i_busy_mode, i_autoack, 6'h09});
    expect_bytes();
    send(8'h18);
    expq.push_back({i_busy_mode, i_autoack, 6'h09});
    expect_bytes();
    // Normal state with a busy bus must hold the new feature back.
    i_mode = 2'h3;
    i_bus_idle = 1'b0;
    send(8'h1C);
    repeat (10) @(posedge i_clk);
    chk(8'(got.size()), 8'h00);
    #1 i_bus_idle = 1'b1;
    expq.push_back({i_busy_mode, i_autoack, 6'h29});
    expect_bytes();
    chk({5'h00, o_feat}, 8'h05);
    i_mode = 2'h2;
    // Register services only in the stop state with nothing pending.
    for (int a = 0; a < 8; a++) begin
      i_reg_rdat = 8'($random(seed));
      send(8'h28 | 8'(a));
      send(i_reg_rdat ^ 8'h5A);
      repeat (3) @(posedge i_clk);
      chk({5'h00, wr_a}, 8'(a));
      chk(wr_d, i_reg_rdat ^ 8'h5A);
      send(8'h38 | 8'(a));
      expq.push_back(i_reg_rdat);
      expect_bytes();
      chk({5'h00, rd_a}, 8'(a));
    end
    send(8'hE5);
    send(8'h3C);
    send(8'hA6);
    repeat (3) @(posedge i_clk);
    chk({poll_vld, 3'h0, poll_slot}, 8'h85);
    chk(poll_adr, 8'h3C);
    chk(poll_dat, 8'hA6);
    frame(1'b1, 2'h0);
    frame(1'b0, 2'h0);
    frame(1'b0, 2'h1);
    repeat_en = 1'b1;
    frame(1'b0, 2'h2);
    #1 i_rst_b = 1'b0;
    @(posedge i_clk);
    #1 i_rst_b = 1'b1;
    chk({5'h00, o_feat}, 8'h00);
    // Received frame with CRC on and marker off: no doubling, silence at the end.
    send(8'h1A);
    expq.push_back({i_busy_mode, i_autoack, 6'h11});
    expect_bytes();
    for (int k = 0; k < 5; k++) begin
      @(posedge i_clk);
      #1 rx = {1'b1, (k == 2) ? 8'hCB : 8'($random(seed))};
      crc_exp = crc_next(crc_exp, rx.dat);
      expq.push_back(rx.dat);
      @(posedge i_clk);
      #1 rx = '0;
    end
    @(posedge i_clk);
    #1 rx_end = 1'b1;
    rx_flg = 3'($random(seed));
    @(posedge i_clk);
    #1 rx_end = 1'b0;
    expq.push_back(crc_exp[15:8]);
    expq.push_back(crc_exp[7:0]);
    expq.push_back({rx_flg, 5'h03});
    expect_bytes();
    print_verdict();
  end
endmodule
